//--- src/pcu_pkg.sv
// Purpose: Shared constants for the position capture unit
// Assumes: Parameter addresses are 16-bit fieldbus parameter numbers
// Notes:   Position and delta are two's complement user units
package pcu_pkg;

    // ------------------------------------------------------------
    // Parameter addresses
    // ------------------------------------------------------------
    localparam logic [15:0] ADDR_DONE_FLAGS = 16'h0A02;  // Capture done flags
    localparam logic [15:0] ADDR_EDGE_SEL   = 16'h0A04;  // Capture edge select
    localparam logic [15:0] ADDR_MODE_CTRL  = 16'h0A08;  // Capture mode control
    localparam logic [15:0] ADDR_POS_VALUE  = 16'h0A0C;  // Captured position
    localparam logic [15:0] ADDR_TALLY      = 16'h0A10;  // Capture event tally

    // ------------------------------------------------------------
    // Field values and reset values
    // ------------------------------------------------------------
    localparam logic [15:0] MODE_STOP       = 16'h0000;  // Cancel capture
    localparam logic [15:0] MODE_ONCE       = 16'h0001;  // Single capture
    localparam logic [15:0] MODE_CONT       = 16'h0002;  // Continuous capture
    localparam logic        EDGE_FALL       = 1'h0;      // 1 to 0 transition
    localparam logic        EDGE_RISE       = 1'h1;      // 0 to 1 transition
    localparam int          FLAG_FIRST_BIT  = 0;         // Done flag position
    localparam logic        EDGE_SEL_RST    = 1'h0;      // Edge select reset
    localparam logic [15:0] TALLY_RST       = 16'h0000;  // Tally reset value
    localparam logic [31:0] POS_RST         = 32'h0000_0000;

    // ------------------------------------------------------------
    // Capture states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PCU_IDLE = 2'b00,  // Not armed
        PCU_ONCE = 2'b01,  // Armed for one capture
        PCU_CONT = 2'b10   // Armed for every selected edge
    } pcu_state_t;

endpackage : pcu_pkg

//--- src/pcu_capture.sv
// Purpose: Position capture unit behind fieldbus parameters
// Assumes: One clock at 40 MHz, synchronous active-high reset
// Notes:   Capture pin is asynchronous and is synchronised here
//
// How it works
// - Mode 0 stops, 1 arms once, 2 continuous
// - Single mode takes one position, then disarms
// - Continuous mode overwrites position on every selected edge
// - Edge select 0 falling, 1 rising
// - 16-bit tally counts each performed capture not made in an arming write cycle
// - Arming single or continuous clears the tally
// - Store signed 32-bit position at edge time
// - Reference change shifts stored position accordingly
// - Done flag bit 0 set after capture
module pcu_capture (
    // Clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        rst_i,
    // Capture pin
    input  wire logic        first_latch_input_i,
    // Axis position and reference changes
    input  wire logic [31:0] axis_position_i,
    input  wire logic        ref_update_i,
    input  wire logic [31:0] ref_delta_i,
    // Parameter access port
    input  wire logic        par_wr_i,
    input  wire logic        par_rd_i,
    input  wire logic [15:0] par_addr_i,
    input  wire logic [31:0] par_wdata_i,
    output logic      [31:0] par_rdata_o,
    output logic             par_rvalid_o,
    // Status
    output logic             capture_active_o,
    output logic             capture_event_o
);

    // ------------------------------------------------------------
    // State record
    // ------------------------------------------------------------
    typedef struct packed {
        pcu_pkg::pcu_state_t st;        // Capture state
        logic                edge_sel;  // Selected edge
        logic [15:0]         tally;     // Event tally
        logic [31:0]         pos;       // Captured position
        logic                done;      // Done flag bit 0
        logic                sync1;     // Synchroniser stage 1
        logic                sync2;     // Synchroniser stage 2
        logic                prev;      // Previous synced level
        logic [31:0]         pos_d1;    // Position delay 1
        logic [31:0]         pos_d2;    // Position delay 2
        logic [31:0]         rdata;     // Read data
        logic                rvalid;    // Read answer strobe
    } pcu_regs_t;

    pcu_regs_t s_q;  // Registered state
    pcu_regs_t s_d;  // Next state
    logic      evt;  // Capture performed this cycle
    logic      rise; // Rising edge seen
    logic      fall; // Falling edge seen
    logic      arm;  // Arming write this cycle
    logic      wr_mode; // Mode write this cycle

    // ------------------------------------------------------------
    // Edge detection and capture decision
    // ------------------------------------------------------------
    always_comb begin
        // Edges from the second stage only
        rise    = s_q.sync2 & ~s_q.prev;
        fall    = ~s_q.sync2 & s_q.prev;
        // Qualifying edge while armed
        evt     = (s_q.st != pcu_pkg::PCU_IDLE) &&
                  ((s_q.edge_sel == pcu_pkg::EDGE_RISE) ? rise : fall);
        wr_mode = par_wr_i && (par_addr_i == pcu_pkg::ADDR_MODE_CTRL);
        arm     = wr_mode && ((par_wdata_i[15:0] == pcu_pkg::MODE_ONCE) ||
                              (par_wdata_i[15:0] == pcu_pkg::MODE_CONT));
    end

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        // Synchroniser and position pipeline aligned with it
        s_d.sync1  = first_latch_input_i;
        s_d.sync2  = s_q.sync1;
        s_d.prev   = s_q.sync2;
        s_d.pos_d1 = axis_position_i;
        s_d.pos_d2 = s_q.pos_d1;

        // Capture under the current mode
        if (evt) begin
            s_d.pos   = s_q.pos_d2;
            s_d.tally = s_q.tally + 16'h0001;
            s_d.done  = 1'h1;
            if (s_q.st == pcu_pkg::PCU_ONCE) begin
                s_d.st = pcu_pkg::PCU_IDLE;
            end
        end

        // Reference change moves the stored value into the new frame
        if (ref_update_i) begin
            s_d.pos = s_d.pos + ref_delta_i;
        end

        // Parameter writes
        if (par_wr_i) begin
            case (par_addr_i)
                pcu_pkg::ADDR_EDGE_SEL: begin
                    s_d.edge_sel = par_wdata_i[0];
                end
                pcu_pkg::ADDR_MODE_CTRL: begin
                    case (par_wdata_i[15:0])
                        pcu_pkg::MODE_STOP: begin
                            s_d.st = pcu_pkg::PCU_IDLE;
                        end
                        pcu_pkg::MODE_ONCE: begin
                            s_d.st = pcu_pkg::PCU_ONCE;
                        end
                        pcu_pkg::MODE_CONT: begin
                            s_d.st = pcu_pkg::PCU_CONT;
                        end
                        default: begin
                            // Out of range values are ignored
                        end
                    endcase
                    if (arm) begin
                        s_d.tally = pcu_pkg::TALLY_RST;
                        s_d.done  = evt;                // Set wins over clear
                    end
                end
                default: begin
                    // Read-only and unmapped writes ignored
                end
            endcase
        end

        // Read answers one cycle later
        s_d.rvalid = par_rd_i;
        s_d.rdata  = 32'h0000_0000;
        if (par_rd_i) begin
            case (par_addr_i)
                pcu_pkg::ADDR_DONE_FLAGS: begin
                    s_d.rdata[pcu_pkg::FLAG_FIRST_BIT] = s_q.done;
                end
                pcu_pkg::ADDR_EDGE_SEL: begin
                    s_d.rdata[0] = s_q.edge_sel;
                end
                pcu_pkg::ADDR_MODE_CTRL: begin
                    s_d.rdata[1:0] = s_q.st;
                end
                pcu_pkg::ADDR_POS_VALUE: begin
                    s_d.rdata = s_q.pos;
                end
                pcu_pkg::ADDR_TALLY: begin
                    s_d.rdata[15:0] = s_q.tally;
                end
                default: begin
                    // Unmapped reads return zero
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            s_q          <= '0;
            s_q.st       <= pcu_pkg::PCU_IDLE;
            s_q.edge_sel <= pcu_pkg::EDGE_SEL_RST;
            s_q.tally    <= pcu_pkg::TALLY_RST;
            s_q.pos      <= pcu_pkg::POS_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign par_rdata_o      = s_q.rdata;
    assign par_rvalid_o     = s_q.rvalid;
    assign capture_active_o = (s_q.st != pcu_pkg::PCU_IDLE);
    assign capture_event_o  = evt;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_stop_write;
        @(posedge sys_clk_i) disable iff (rst_i)
        wr_mode && (par_wdata_i[15:0] == pcu_pkg::MODE_STOP) |=> !capture_active_o;
    endproperty
    a_stop_write: assert property (p_stop_write) else $error("stop write left unit armed");

    property p_once_ends;
        @(posedge sys_clk_i) disable iff (rst_i)
        (s_q.st == pcu_pkg::PCU_ONCE) && evt && !wr_mode |=> (s_q.st == pcu_pkg::PCU_IDLE) && !evt;
    endproperty
    a_once_ends: assert property (p_once_ends) else $error("single capture did not end");

    property p_cont_stays;
        @(posedge sys_clk_i) disable iff (rst_i)
        (s_q.st == pcu_pkg::PCU_CONT) && !wr_mode |=> (s_q.st == pcu_pkg::PCU_CONT);
    endproperty
    a_cont_stays: assert property (p_cont_stays) else $error("continuous capture stopped");

    property p_edge_kind;
        @(posedge sys_clk_i) disable iff (rst_i)
        evt |-> (s_q.sync2 == s_q.edge_sel) && (s_q.prev != s_q.edge_sel);
    endproperty
    a_edge_kind: assert property (p_edge_kind) else $error("capture on wrong edge");

    property p_tally_inc;
        @(posedge sys_clk_i) disable iff (rst_i)
        evt && !arm |=> s_q.tally == $past(s_q.tally) + 16'h0001;
    endproperty
    a_tally_inc: assert property (p_tally_inc) else $error("tally did not advance");

    property p_tally_clear;
        @(posedge sys_clk_i) disable iff (rst_i)
        arm |=> (s_q.tally == 16'h0000) && capture_active_o;
    endproperty
    a_tally_clear: assert property (p_tally_clear) else $error("arming did not clear tally");

    property p_pos_taken;
        @(posedge sys_clk_i) disable iff (rst_i)
        evt && !ref_update_i |=> s_q.pos == $past(axis_position_i, 3);
    endproperty
    a_pos_taken: assert property (p_pos_taken) else $error("captured position wrong");

    property p_ref_shift;
        @(posedge sys_clk_i) disable iff (rst_i)
        ref_update_i && !evt |=> s_q.pos == $past(s_q.pos) + $past(ref_delta_i);
    endproperty
    a_ref_shift: assert property (p_ref_shift) else $error("position not moved to new frame");

    property p_done_set;
        @(posedge sys_clk_i) disable iff (rst_i)
        evt |=> s_q.done;
    endproperty
    a_done_set: assert property (p_done_set) else $error("done flag not set");

    property p_sync_path;
        @(posedge sys_clk_i) disable iff (rst_i)
        evt |-> $past(first_latch_input_i, 2) == s_q.sync2;
    endproperty
    a_sync_path: assert property (p_sync_path) else $error("edge not two stages behind pin");

endmodule : pcu_capture

//--- verification/pcu_pin_model.sv
// Purpose: Far-side model of the external capture pin
// Assumes: Bench requests a level, pin follows off the clock grid
// Notes:   Pin changes between edges so the synchroniser sees it raw
module pcu_pin_model (
    // Clock
    input  wire logic sys_clk_i,
    // Requested level
    input  wire logic level_i,
    // Capture pin
    output logic      first_latch_input_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle low at start
    initial first_latch_input_o = 1'b0;

    // Apply level 3 ns after the falling edge, unrelated to sampling
    always @(negedge sys_clk_i) begin
        #3;
        first_latch_input_o <= level_i;
    end
endmodule : pcu_pin_model

//--- verification/tb_position_capture_unit.sv
// Purpose: Self-checking bench for the position capture unit
// Assumes: 40 MHz clock, synchronous active-high reset
// Notes:   Axis position held steady across each pin pulse
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin miscompares++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, a, e); end end
module tb_position_capture_unit;
    timeunit 1ns;
    timeprecision 1ps;
    // ----
    // Stimulus and observed signals
    // ----
    logic        sys_clk_i       = 1'b0;
    logic        rst_i           = 1'b1;
    logic        pin_lvl         = 1'b0;  // Level asked of the pin model
    logic        first_latch_input_i;
    logic [31:0] axis_position_i = 32'h0000_0000;
    logic        ref_update_i    = 1'b0;
    logic [31:0] ref_delta_i     = 32'h0000_0000;
    logic        par_wr_i        = 1'b0;
    logic        par_rd_i        = 1'b0;
    logic [15:0] par_addr_i      = 16'h0000;
    logic [31:0] par_wdata_i     = 32'h0000_0000;
    logic [31:0] par_rdata_o;
    logic        par_rvalid_o;
    logic        capture_active_o;
    logic        capture_event_o;
    logic [15:0] ev_cnt          = 16'h0000;  // Event pulses seen
    int          miscompares     = 0;
    int          tests_run       = 0;

    pcu_pin_model u_pcu_pin_model (.sys_clk_i(sys_clk_i), .level_i(pin_lvl),
        .first_latch_input_o(first_latch_input_i));
    pcu_capture u_pcu_capture (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .first_latch_input_i(first_latch_input_i), .axis_position_i(axis_position_i),
        .ref_update_i(ref_update_i), .ref_delta_i(ref_delta_i), .par_wr_i(par_wr_i),
        .par_rd_i(par_rd_i), .par_addr_i(par_addr_i), .par_wdata_i(par_wdata_i),
        .par_rdata_o(par_rdata_o), .par_rvalid_o(par_rvalid_o),
        .capture_active_o(capture_active_o), .capture_event_o(capture_event_o));

    // Clock, 25 ns period
    initial begin
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end

    // Count one-cycle capture pulses
    always @(posedge sys_clk_i) begin
        if (capture_event_o === 1'b1) ev_cnt <= ev_cnt + 16'h0001;
    end

    // ----
    // Access tasks
    // ----
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        par_wr_i    <= 1'b1;
        par_addr_i  <= a;
        par_wdata_i <= d;
        @(posedge sys_clk_i);
        par_wr_i    <= 1'b0;
    endtask : wr

    task automatic rd_chk(input logic [15:0] a, input logic [31:0] e);
        @(posedge sys_clk_i);
        par_rd_i   <= 1'b1;
        par_addr_i <= a;
        @(posedge sys_clk_i);
        par_rd_i   <= 1'b0;
        #1;
        `CHK(par_rvalid_o, 1'b1)
        `CHK(par_rdata_o, e)
    endtask : rd_chk

    // One pin pulse: toggle, hold 6 cycles, toggle back, hold 6
    task automatic pulse(input logic [31:0] p);
        @(posedge sys_clk_i);
        axis_position_i <= p;
        pin_lvl         <= ~pin_lvl;
        repeat (6) @(posedge sys_clk_i);
        pin_lvl         <= ~pin_lvl;
        repeat (6) @(posedge sys_clk_i);
    endtask : pulse

    task automatic complete_run();
        $display("Compares %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : complete_run

    // Watchdog, run needs about 150 cycles
    initial begin
        repeat (3000) @(posedge sys_clk_i);
        miscompares++;
        complete_run();
    end

    // ----
    // Test sequence
    // ----
    initial begin
        repeat (4) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        rd_chk(pcu_pkg::ADDR_EDGE_SEL, 32'h0000_0000);
        rd_chk(pcu_pkg::ADDR_MODE_CTRL, 32'h0000_0000);
        rd_chk(pcu_pkg::ADDR_TALLY, 32'h0000_0000);
        rd_chk(pcu_pkg::ADDR_POS_VALUE, 32'h0000_0000);
        rd_chk(pcu_pkg::ADDR_DONE_FLAGS, 32'h0000_0000);
        rd_chk(16'h0A06, 32'h0000_0000);
        pulse(32'h0000_0055);                                // Idle, ignored
        // Single capture on rising edges, second pulse ignored
        wr(pcu_pkg::ADDR_EDGE_SEL, 32'h0000_0001);
        wr(pcu_pkg::ADDR_MODE_CTRL, {16'h0000, pcu_pkg::MODE_ONCE});
        #1 `CHK(capture_active_o, 1'b1)
        pulse(32'hFFFF_FF00);
        pulse(32'h0000_1234);
        #1 `CHK(capture_active_o, 1'b0)
        `CHK(ev_cnt, 16'h0001)
        rd_chk(pcu_pkg::ADDR_POS_VALUE, 32'hFFFF_FF00);
        rd_chk(pcu_pkg::ADDR_TALLY, 32'h0000_0001);
        rd_chk(pcu_pkg::ADDR_DONE_FLAGS, 32'h0000_0001);
        rd_chk(pcu_pkg::ADDR_MODE_CTRL, 32'h0000_0000);
        wr(pcu_pkg::ADDR_TALLY, 32'h0000_0005);              // Read-only
        rd_chk(pcu_pkg::ADDR_TALLY, 32'h0000_0001);
        // Continuous on falling edges, tally cleared on arming
        wr(pcu_pkg::ADDR_EDGE_SEL, 32'h0000_0000);
        wr(pcu_pkg::ADDR_MODE_CTRL, {16'h0000, pcu_pkg::MODE_CONT});
        rd_chk(pcu_pkg::ADDR_TALLY, 32'h0000_0000);
        rd_chk(pcu_pkg::ADDR_DONE_FLAGS, 32'h0000_0000);
        pulse(32'h0000_0A00);
        pulse(32'h8000_0001);
        rd_chk(pcu_pkg::ADDR_POS_VALUE, 32'h8000_0001);
        rd_chk(pcu_pkg::ADDR_TALLY, 32'h0000_0002);
        rd_chk(pcu_pkg::ADDR_DONE_FLAGS, 32'h0000_0001);
        rd_chk(pcu_pkg::ADDR_MODE_CTRL, 32'h0000_0002);
        // Reference change shifts stored position
        @(posedge sys_clk_i);
        ref_update_i <= 1'b1;
        ref_delta_i  <= 32'h0000_0010;
        @(posedge sys_clk_i);
        ref_update_i <= 1'b0;
        rd_chk(pcu_pkg::ADDR_POS_VALUE, 32'h8000_0011);
        // Bad mode value leaves continuous running, then stop
        wr(pcu_pkg::ADDR_MODE_CTRL, 32'h0000_0003);
        rd_chk(pcu_pkg::ADDR_MODE_CTRL, 32'h0000_0002);
        wr(pcu_pkg::ADDR_MODE_CTRL, {16'h0000, pcu_pkg::MODE_STOP});
        pulse(32'h0000_0777);
        rd_chk(pcu_pkg::ADDR_TALLY, 32'h0000_0002);
        rd_chk(pcu_pkg::ADDR_POS_VALUE, 32'h8000_0011);
        `CHK(ev_cnt, 16'h0003)
        // Mid-run reset returns the parameters to reset values
        @(posedge sys_clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        rd_chk(pcu_pkg::ADDR_TALLY, 32'h0000_0000);
        rd_chk(pcu_pkg::ADDR_POS_VALUE, 32'h0000_0000);
        rd_chk(pcu_pkg::ADDR_DONE_FLAGS, 32'h0000_0000);
        complete_run();
    end
endmodule : tb_position_capture_unit
